// ==== logic/ppe_consts.svh ====
// Constants for the PHY power and event field block
`ifndef PPE_CONSTS_SVH
`define PPE_CONSTS_SVH

// Register offsets on the plain register port
`define PPE_ADDR_W 3
`define PPE_OFF_CTRL 3'h0
`define PPE_OFF_EVENT 3'h1
`define PPE_OFF_IRQ_STATUS 3'h2
`define PPE_OFF_IRQ_CLEAR 3'h3
`define PPE_OFF_IRQ_ENABLE 3'h4

// Field positions
`define PPE_CTRL_PWR_LSB 0
`define PPE_CTRL_WDEN_BIT 3
`define PPE_CTRL_SREQ_BIT 4
`define PPE_CTRL_JIT_LSB 5
`define PPE_EV_CFG_BIT 0
`define PPE_EV_CPS_BIT 1
`define PPE_EV_STO_BIT 2
`define PPE_EV_PORT_BIT 3
`define PPE_IRQ_SRDONE_BIT 3

// Reset values
`define PPE_CTRL_RESET 8'h00
`define PPE_EVENT_RESET 4'h2
`define PPE_JITTER_VALUE 3'h0
`define PPE_IRQ_RESET 4'h0

// Timing
`define PPE_CLK_PERIOD_NS 25
`define PPE_SHORT_RESET_US 1300
`define PPE_SHORT_RESET_CYCLES (`PPE_SHORT_RESET_US * 1000 / `PPE_CLK_PERIOD_NS)
`define PPE_SR_CNT_W 16

`endif

// ==== logic/ppe_pkg.sv ====
// Types shared by the PHY power and event field block
package ppe_pkg;

    // Control register layout, bit 0 upward: power class, enable, request, jitter
    typedef struct packed {
        logic [2:0] jitter;
        logic short_reset_request;
        logic resume_watch_irq_enable;
        logic [2:0] power_class;
    } ppe_ctrl_type;

    // Event flag layout, bit 3 downward
    typedef struct packed {
        logic port_event_flag;
        logic state_timeout_flag;
        logic cable_power_flag;
        logic config_timeout_flag;
    } ppe_event_type;

    // Short reset timer
    typedef enum logic {PPE_SR_IDLE, PPE_SR_RUN} ppe_sr_mode_type;

    typedef struct packed {
        ppe_sr_mode_type mode;
        logic active;
        logic done;
        logic [15:0] count;
    } ppe_sr_state_type;

    // Whole state of the top module
    typedef struct packed {
        ppe_ctrl_type ctrl;
        ppe_event_type events;
        logic [3:0] irq_status;
        logic [3:0] irq_enable;
        logic cps_prev;
        logic strap_pending;
        logic [7:0] rdata;
        logic irq;
        logic link_wake;
        logic bus_reset_req;
    } ppe_state_type;

endpackage

// ==== logic/ppe_short_reset.sv ====
// Timer that holds the short arbitrated bus reset for its full length
`timescale 1ns/100ps
`include "ppe_consts.svh"
module ppe_short_reset #(
    parameter logic [15:0] CYCLES = 16'(`PPE_SHORT_RESET_CYCLES)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    output logic active_o,
    output logic done_o
);
    ppe_pkg::ppe_sr_state_type s;
    ppe_pkg::ppe_sr_state_type next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Count down the reset; done is a one-cycle pulse at the end
    always_comb
    begin
        next_s = s;
        if (ce_i)
        begin
            // Done only drops on an enabled edge, so a frozen clock cannot swallow it
            next_s.done = 1'b0;
            case (s.mode)
                ppe_pkg::PPE_SR_IDLE:
                begin
                    if (start_i)
                    begin
                        next_s.mode = ppe_pkg::PPE_SR_RUN;
                        next_s.active = 1'b1;
                        next_s.count = CYCLES - 16'h0001;
                    end
                end
                ppe_pkg::PPE_SR_RUN:
                begin
                    if (s.count == 16'h0000)
                    begin
                        next_s.mode = ppe_pkg::PPE_SR_IDLE;
                        next_s.active = 1'b0;
                        next_s.done = 1'b1;
                    end
                    else
                    begin
                        next_s.count = s.count - 16'h0001;
                    end
                end
                default:
                begin
                    next_s.mode = ppe_pkg::PPE_SR_IDLE;
                    next_s.active = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign active_o = s.active;
    assign done_o = s.done;

    ////////////////////////////////////////////////////////////////////////////
    // Reset length is exactly CYCLES enabled cycles
    short_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.active && s.count == 16'h0000 |=> !active_o && done_o)
        else $error("short reset did not end at the programmed length");
    short_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !s.active && start_i |=> active_o && s.count == CYCLES - 16'h0001)
        else $error("short reset did not start on request");
endmodule

// ==== logic/ppe_top.sv ====
// PHY power class, resume/watch enable, short reset request and event flags
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "ppe_consts.svh"
module ppe_top #(
    parameter int unsigned SHORT_RESET_CYCLES = `PPE_SHORT_RESET_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic [`PPE_ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [2:0] POWER_CLASS_STRAPS_I,
    input wire logic CABLE_POWER_SENSE_I,
    input wire logic LINK_POWER_STATUS_I,
    input wire logic ARB_CONFIG_TIMEOUT_I,
    input wire logic LEGACY_NODES_I,
    input wire logic STATE_TIMEOUT_I,
    input wire logic RESUME_START_I,
    input wire logic BUS_RESET_I,
    input wire logic ARB_OPPORTUNITY_I,
    output logic [7:0] RDATA_O,
    output logic [2:0] SELFID_PWR_O,
    output logic LINK_WAKE_OUTPUT_O,
    output logic SHORT_RESET_ACTIVE_O,
    output logic BUS_RESET_REQ_O,
    output logic IRQ_O
);
    localparam ppe_pkg::ppe_state_type RESET_STATE = '{
        ctrl: ppe_pkg::ppe_ctrl_type'(`PPE_CTRL_RESET),
        events: ppe_pkg::ppe_event_type'(`PPE_EVENT_RESET),
        irq_status: `PPE_IRQ_RESET,
        irq_enable: `PPE_IRQ_RESET,
        cps_prev: 1'b0,
        strap_pending: 1'b1,
        rdata: 8'h00,
        irq: 1'b0,
        link_wake: 1'b0,
        bus_reset_req: 1'b0
    };

    ppe_pkg::ppe_state_type s;
    ppe_pkg::ppe_state_type next_s;
    ppe_pkg::ppe_event_type ev_set;
    ppe_pkg::ppe_event_type ev_clr;
    logic [2:0] ev_new;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic link_off;
    logic sr_start;
    logic sr_active;
    logic sr_done;

    // Register decode for the write paths; the read path decodes ADDR_I in its own case
    function automatic logic hit(input logic [`PPE_ADDR_W-1:0] addr,
                                 input logic [`PPE_ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction

    // Sticky update where a setting event always beats a clearing write
    function automatic logic [3:0] sticky(input logic [3:0] cur, input logic [3:0] set,
                                          input logic [3:0] clr);
        sticky = (cur & ~clr) | set;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event sources
    always_comb
    begin
        link_off = !LINK_POWER_STATUS_I;
        ev_set = '0;
        // Without legacy nodes loop healing prevents loops, so no time-out is flagged
        ev_set.config_timeout_flag = ARB_CONFIG_TIMEOUT_I && LEGACY_NODES_I;
        ev_set.cable_power_flag = s.cps_prev && !CABLE_POWER_SENSE_I;
        ev_set.state_timeout_flag = STATE_TIMEOUT_I;
        // Only a flag going from clear to set counts as becoming set
        ev_new = {ev_set.state_timeout_flag && !s.events.state_timeout_flag,
                  ev_set.cable_power_flag && !s.events.cable_power_flag,
                  ev_set.config_timeout_flag && !s.events.config_timeout_flag};
        ev_set.port_event_flag = s.ctrl.resume_watch_irq_enable &&
            (RESUME_START_I || ((|ev_new) && link_off));
        // Only ones in the written word clear; zeros leave flags alone
        ev_clr = '0;
        if (WR_I && hit(ADDR_I, `PPE_OFF_EVENT))
            ev_clr = ppe_pkg::ppe_event_type'(WDATA_I[3:0]);
        irq_set = {sr_done, ev_set.state_timeout_flag, ev_set.cable_power_flag,
                   ev_set.config_timeout_flag};
        irq_clr = '0;
        if (WR_I && hit(ADDR_I, `PPE_OFF_IRQ_CLEAR))
            irq_clr = WDATA_I[3:0];
    end

    // A short reset waits for the arbiter to grant an opportunity
    assign sr_start = CE_I && s.ctrl.short_reset_request && ARB_OPPORTUNITY_I &&
                      !sr_active;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_s = s;
        if (CE_I)
        begin
            next_s.cps_prev = CABLE_POWER_SENSE_I;
            // Straps are caught on the first enabled edge after reset release
            if (s.strap_pending)
            begin
                next_s.ctrl.power_class = POWER_CLASS_STRAPS_I;
                next_s.strap_pending = 1'b0;
            end
            // Starting the short reset is itself a bus reset and retires the request
            if (BUS_RESET_I || sr_start)
                next_s.ctrl.short_reset_request = 1'b0;
            // Software writes; a fresh request after a bus reset is kept
            if (WR_I && hit(ADDR_I, `PPE_OFF_CTRL))
            begin
                next_s.ctrl.power_class = WDATA_I[`PPE_CTRL_PWR_LSB +: 3];
                next_s.ctrl.resume_watch_irq_enable = WDATA_I[`PPE_CTRL_WDEN_BIT];
                if (WDATA_I[`PPE_CTRL_SREQ_BIT])
                    next_s.ctrl.short_reset_request = 1'b1;
            end
            next_s.ctrl.jitter = `PPE_JITTER_VALUE;
            if (WR_I && hit(ADDR_I, `PPE_OFF_IRQ_ENABLE))
                next_s.irq_enable = WDATA_I[3:0];
            next_s.events = ppe_pkg::ppe_event_type'(sticky(s.events, ev_set,
                                                            ev_clr));
            next_s.irq_status = sticky(s.irq_status, irq_set, irq_clr);
            next_s.irq = |(next_s.irq_status & next_s.irq_enable);
            // The state time-out also forces a bus reset
            next_s.bus_reset_req = STATE_TIMEOUT_I;
            // Wake the link while it sleeps and an enabled flag is waiting
            next_s.link_wake = next_s.ctrl.resume_watch_irq_enable && link_off &&
                (next_s.events.config_timeout_flag || next_s.events.cable_power_flag ||
                 next_s.events.state_timeout_flag);
            // Read data stands for the one cycle after the strobe only
            next_s.rdata = 8'h00;
            if (RD_I)
            begin
                case (ADDR_I)
                    `PPE_OFF_CTRL: next_s.rdata = s.ctrl;
                    `PPE_OFF_EVENT: next_s.rdata = {4'h0, s.events};
                    `PPE_OFF_IRQ_STATUS: next_s.rdata = {4'h0, s.irq_status};
                    `PPE_OFF_IRQ_ENABLE: next_s.rdata = {4'h0, s.irq_enable};
                    default: next_s.rdata = 8'h00;
                endcase
            end
        end
    end

    // State register; reset takes constants only
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            s <= RESET_STATE;
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Short arbitrated reset timer
    ppe_short_reset #(
        .CYCLES(16'(SHORT_RESET_CYCLES))
    ) u_short_reset (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .start_i(sr_start),
        .active_o(sr_active),
        .done_o(sr_done)
    );

    // Outputs, all straight from flip-flops
    assign RDATA_O = s.rdata;
    assign SELFID_PWR_O = s.ctrl.power_class;
    assign LINK_WAKE_OUTPUT_O = s.link_wake;
    assign SHORT_RESET_ACTIVE_O = sr_active;
    assign BUS_RESET_REQ_O = s.bus_reset_req;
    assign IRQ_O = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    jitter_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && RD_I && ADDR_I == `PPE_OFF_CTRL |=> RDATA_O[7:5] == 3'h0)
        else $error("jitter field read nonzero");

    pwr_copy_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && WR_I && ADDR_I == `PPE_OFF_CTRL
        |=> SELFID_PWR_O == $past(WDATA_I[2:0]))
        else $error("self-ID power class does not follow the written value");

    strap_load_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && s.strap_pending && !(WR_I && ADDR_I == `PPE_OFF_CTRL)
        |=> SELFID_PWR_O == $past(POWER_CLASS_STRAPS_I) && !s.strap_pending)
        else $error("power class not loaded from straps");

    bus_reset_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && BUS_RESET_I && !s.strap_pending && !(WR_I && ADDR_I == `PPE_OFF_CTRL)
        |=> $stable(SELFID_PWR_O) && $stable(s.ctrl.resume_watch_irq_enable))
        else $error("bus reset changed a field it must keep");

    resume_event_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && s.ctrl.resume_watch_irq_enable && RESUME_START_I
        |=> s.events.port_event_flag)
        else $error("resume start did not set the port event flag");

    wake_event_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && s.ctrl.resume_watch_irq_enable && !LINK_POWER_STATUS_I &&
        STATE_TIMEOUT_I && !s.events.state_timeout_flag |=> s.events.port_event_flag)
        else $error("flag rise with link down did not set the port event flag");

    req_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && BUS_RESET_I && !WR_I |=> !s.ctrl.short_reset_request)
        else $error("bus reset did not clear the short reset request");

    cfg_legacy_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && !s.events.config_timeout_flag && ARB_CONFIG_TIMEOUT_I
        |=> s.events.config_timeout_flag == $past(LEGACY_NODES_I))
        else $error("config time-out flag wrong for the topology");

    cable_fall_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && s.cps_prev && !CABLE_POWER_SENSE_I |=> s.events.cable_power_flag)
        else $error("cable sense fall did not set the cable flag");

    flag_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && WR_I && ADDR_I == `PPE_OFF_EVENT && WDATA_I[`PPE_EV_STO_BIT] &&
        !STATE_TIMEOUT_I |=> !s.events.state_timeout_flag)
        else $error("writing one did not clear the state time-out flag");

    timeout_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && STATE_TIMEOUT_I |=> BUS_RESET_REQ_O ##1 !BUS_RESET_REQ_O || $past(
        STATE_TIMEOUT_I))
        else $error("state time-out did not request one bus reset");

    link_wake_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        LINK_WAKE_OUTPUT_O |-> !$past(LINK_POWER_STATUS_I) &&
        s.ctrl.resume_watch_irq_enable)
        else $error("link wake asserted while the link is powered or disabled");

    // Main scenarios
    short_reset_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        sr_start ##1 SHORT_RESET_ACTIVE_O);
    link_wake_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(LINK_WAKE_OUTPUT_O));
    port_event_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(s.events.port_event_flag));
    irq_raise_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(IRQ_O));
endmodule

// ==== sim/ppe_far_end.sv ====
// Behavioural model of the link layer and cable bus facing the event block
`timescale 1ns/100ps
module ppe_far_end (
    input wire logic clk_i,
    output logic cable_power_sense_o,
    output logic link_power_status_o,
    output logic arb_config_timeout_o,
    output logic legacy_nodes_o,
    output logic state_timeout_o,
    output logic resume_start_o,
    output logic bus_reset_o,
    output logic arb_opportunity_o
);
    // Idle bus: cable powered, link up, no events, arbiter busy
    initial
    begin
        cable_power_sense_o = 1'b1;
        link_power_status_o = 1'b1;
        arb_config_timeout_o = 1'b0;
        legacy_nodes_o = 1'b0;
        state_timeout_o = 1'b0;
        resume_start_o = 1'b0;
        bus_reset_o = 1'b0;
        arb_opportunity_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle event pulse: 0 config time-out, 1 state time-out, 2 resume, 3 bus reset
    task automatic pulse(input int sel);
        case (sel)
            0: arb_config_timeout_o <= 1'b1;
            1: state_timeout_o <= 1'b1;
            2: resume_start_o <= 1'b1;
            default: bus_reset_o <= 1'b1;
        endcase
        @(posedge clk_i);
        arb_config_timeout_o <= 1'b0;
        state_timeout_o <= 1'b0;
        resume_start_o <= 1'b0;
        bus_reset_o <= 1'b0;
        @(posedge clk_i);
    endtask

    // Level change: 0 cable sense, 1 link power, 2 legacy nodes, 3 arbiter opportunity
    task automatic level(input int sel, input logic v);
        case (sel)
            0: cable_power_sense_o <= v;
            1: link_power_status_o <= v;
            2: legacy_nodes_o <= v;
            default: arb_opportunity_o <= v;
        endcase
        @(posedge clk_i);
    endtask
endmodule

// ==== sim/tb_ppe_top.sv ====
// Self-checking testbench for the PHY power and event field block
`timescale 1ns/100ps
`include "ppe_consts.svh"
module tb_ppe_top;
    localparam int SR_CYC = 8;
    typedef struct {
        int kind;
        logic [7:0] exp;
        string name;
    } ppe_note_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce;
    logic [`PPE_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [2:0] straps;
    logic [2:0] ps;
    logic [2:0] pc;
    logic cable_power_sense, link_power_status, cfg, leg, sto, res, bres, opp;
    logic [7:0] rdata;
    logic [2:0] selfid;
    logic wake, active, brq, irq;
    logic rd_q = 1'b0;
    logic [7:0] measured;
    int n_fail = 0;
    int compares = 0;
    ppe_note_type notes[$];

    always #12.5 clk = ~clk;

    ppe_far_end far (.clk_i(clk), .cable_power_sense_o(cable_power_sense), .link_power_status_o(link_power_status),
        .arb_config_timeout_o(cfg), .legacy_nodes_o(leg), .state_timeout_o(sto),
        .resume_start_o(res), .bus_reset_o(bres), .arb_opportunity_o(opp));

    ppe_top #(.SHORT_RESET_CYCLES(SR_CYC)) uut (.CLK_I(clk), .RST_I(rst), .CE_I(ce),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .POWER_CLASS_STRAPS_I(straps),
        .CABLE_POWER_SENSE_I(cable_power_sense), .LINK_POWER_STATUS_I(link_power_status), .ARB_CONFIG_TIMEOUT_I(cfg),
        .LEGACY_NODES_I(leg), .STATE_TIMEOUT_I(sto), .RESUME_START_I(res),
        .BUS_RESET_I(bres), .ARB_OPPORTUNITY_I(opp), .RDATA_O(rdata), .SELFID_PWR_O(selfid),
        .LINK_WAKE_OUTPUT_O(wake), .SHORT_RESET_ACTIVE_O(active), .BUS_RESET_REQ_O(brq),
        .IRQ_O(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence and from the watchdog
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Monitor: read data is compared in the cycle after the strobe, other notes at once
    always @(negedge clk)
    begin
        ppe_note_type n;
        logic [7:0] seen;
        if (notes.size() != 0 && (rd_q || notes[0].kind != 0))
        begin
            n = notes.pop_front();
            case (n.kind)
                0: seen = rdata;
                1: seen = {5'h00, selfid};
                2: seen = {7'h00, wake};
                3: seen = {7'h00, irq};
                4: seen = {7'h00, brq};
                default: seen = measured;
            endcase
            compares++;
            if (n.exp !== seen)
            begin
                n_fail++;
                $display("unexpected %s expected %h seen %h", n.name, n.exp, seen);
            end
        end
    end

    always @(posedge clk)
        rd_q <= rd & ce;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus cycles; one idle cycle after each strobe keeps drivers simple
    task automatic wr_reg(input logic [`PPE_ADDR_W-1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [`PPE_ADDR_W-1:0] a, input logic [7:0] e, input string nm);
        notes.push_back('{0, e, nm});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // Output check: the note is taken at the next falling edge
    task automatic chk(input int k, input logic [7:0] e, input string nm);
        notes.push_back('{k, e, nm});
        @(posedge clk);
    endtask

    function automatic logic [7:0] ctrl_v(input logic rq, input logic en, input logic [2:0] p);
        ctrl_v = {3'h0, rq, en, p};
    endfunction

    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(32'hd3d6b87f));
        ce <= 1'b1;
        addr <= '0;
        wdata <= 8'h00;
        wr <= 1'b0;
        rd <= 1'b0;
        ps = 3'($urandom);
        pc = 3'($urandom);
        straps = ps;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // Reset values, strap load, unmapped read
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b0, 1'b0, ps), "ctrl");
        rd_reg(`PPE_OFF_EVENT, 8'h02, "event");
        chk(1, {5'h00, ps}, "selfid");
        rd_reg(3'h7, 8'h00, "unmapped");
        // Power class write, jitter stays zero, enable set
        wr_reg(`PPE_OFF_CTRL, {3'h7, 1'b0, 1'b1, pc});
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b0, 1'b1, pc), "ctrl");
        chk(1, {5'h00, pc}, "selfid");
        // Link goes down with cable flag pending, then comes back
        chk(2, 8'h00, "wake");
        far.level(1, 1'b0);
        chk(2, 8'h01, "wake");
        far.level(1, 1'b1);
        chk(2, 8'h00, "wake");
        // Bus reset keeps power class and enable
        far.pulse(3);
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b0, 1'b1, pc), "ctrl");
        // Zero write ignored, one write clears
        wr_reg(`PPE_OFF_EVENT, 8'h00);
        rd_reg(`PPE_OFF_EVENT, 8'h02, "event");
        wr_reg(`PPE_OFF_EVENT, 8'h02);
        rd_reg(`PPE_OFF_EVENT, 8'h00, "event");
        // Cable sense falls with link down: flag, port event, wake, interrupt
        wr_reg(`PPE_OFF_IRQ_ENABLE, 8'h02);
        far.level(1, 1'b0);
        far.level(0, 1'b0);
        chk(3, 8'h01, "irq");
        chk(2, 8'h01, "wake");
        far.level(0, 1'b1);
        rd_reg(`PPE_OFF_EVENT, 8'h0a, "event");
        wr_reg(`PPE_OFF_IRQ_STATUS, 8'h00);
        rd_reg(`PPE_OFF_IRQ_STATUS, 8'h02, "irq status");
        wr_reg(`PPE_OFF_IRQ_CLEAR, 8'h02);
        chk(3, 8'h00, "irq");
        rd_reg(`PPE_OFF_IRQ_ENABLE, 8'h02, "irq enable");
        wr_reg(`PPE_OFF_EVENT, 8'h0f);
        chk(2, 8'h00, "wake");
        // Config time-out only counts with legacy nodes present
        far.pulse(0);
        rd_reg(`PPE_OFF_EVENT, 8'h00, "event");
        far.level(2, 1'b1);
        far.pulse(0);
        rd_reg(`PPE_OFF_EVENT, 8'h09, "event");
        chk(2, 8'h01, "wake");
        far.level(1, 1'b1);
        wr_reg(`PPE_OFF_EVENT, 8'h0f);
        // Resume start sets the port event with the link up
        far.pulse(2);
        rd_reg(`PPE_OFF_EVENT, 8'h08, "event");
        wr_reg(`PPE_OFF_EVENT, 8'h0f);
        // State time-out requests a bus reset; a clearing write in the same cycle loses
        fork
            far.pulse(1);
            begin
                @(posedge clk);
                chk(4, 8'h01, "bus reset req");
            end
        join
        fork
            far.pulse(1);
            wr_reg(`PPE_OFF_EVENT, 8'h04);
        join
        rd_reg(`PPE_OFF_EVENT, 8'h04, "event");
        wr_reg(`PPE_OFF_EVENT, 8'h0f);
        // Short reset: software asks only for short resets; a bus reset drops the request
        wr_reg(`PPE_OFF_CTRL, ctrl_v(1'b1, 1'b0, pc));
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b1, 1'b0, pc), "ctrl");
        far.pulse(3);
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b0, 1'b0, pc), "ctrl");
        wr_reg(`PPE_OFF_CTRL, ctrl_v(1'b1, 1'b0, pc));
        far.level(3, 1'b1);
        measured = 8'h00;
        repeat (40)
        begin
            @(negedge clk);
            if (active === 1'b1)
                measured++;
        end
        @(posedge clk);
        chk(5, 8'(SR_CYC), "short reset length");
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b0, 1'b0, pc), "ctrl");
        // Done bit joins the config and state time-out bits that were never cleared
        rd_reg(`PPE_OFF_IRQ_STATUS, 8'h0d, "irq status");
        // Clock enable low refuses a write
        ce <= 1'b0;
        wr_reg(`PPE_OFF_CTRL, 8'h00);
        ce <= 1'b1;
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b0, 1'b0, pc), "ctrl");
        // Mid-run reset with fresh straps; the cable flag is clear before it
        ps = 3'($urandom);
        straps <= ps;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd_reg(`PPE_OFF_CTRL, ctrl_v(1'b0, 1'b0, ps), "ctrl");
        rd_reg(`PPE_OFF_EVENT, 8'h02, "event");
        rd_reg(`PPE_OFF_IRQ_STATUS, 8'h00, "irq status");
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule
